// ===== spw_pkg.sv
package spw_pkg;
  localparam int N_INST = 6;
  localparam int N_EXT = 3;
  localparam int EXT_FIRST = 3;
  localparam int IN_W = 16;
  localparam int VAL_W = 32;
  localparam int PROD_W = 48;
  localparam int CODE_W = 16;
  localparam int SUB_W = 8;
  localparam int AW = 8;
  localparam int OFF_W = 5;
  localparam int IRQ_W = 12;
  localparam int DIV_STEPS = 48;
  localparam logic [5:0] DIV_STEPS_M1 = 6'h2F;
  localparam logic [2:0] GLOBAL_SLOT = 3'h6;
  // ==========================================
  // Register map
  localparam logic [OFF_W-1:0] REG_NUM = 5'h00;
  localparam logic [OFF_W-1:0] REG_DEN = 5'h04;
  localparam logic [OFF_W-1:0] REG_OFFS = 5'h08;
  localparam logic [OFF_W-1:0] REG_CODE = 5'h0C;
  localparam logic [OFF_W-1:0] REG_SUB = 5'h10;
  localparam logic [OFF_W-1:0] REG_DISP = 5'h14;
  localparam logic [OFF_W-1:0] REG_INPUT = 5'h18;
  localparam logic [OFF_W-1:0] REG_STAT = 5'h1C;
  localparam logic [OFF_W-1:0] REG_IRQ_STAT = 5'h00;
  localparam logic [OFF_W-1:0] REG_IRQ_MASK = 5'h04;
  localparam int STAT_BUSY = 0;
  localparam int STAT_FAIL = 1;
  localparam logic [VAL_W-1:0] NUM_RST = 32'h0000_2710;
  localparam logic [VAL_W-1:0] DEN_RST = 32'h0000_2710;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_SCALE = 5'h02,
    ST_LOOKUP = 5'h04,
    ST_WRITE = 5'h08,
    ST_DONE = 5'h10
  } spw_state_t;
  function automatic logic signed [PROD_W-1:0] spw_widen(input logic signed [VAL_W-1:0] v);
    return PROD_W'(v);
  endfunction
endpackage

// ===== spw_scale_if.sv
`timescale 1ns/10ps
interface spw_scale_if;
  import spw_pkg::*;
  logic start;
  logic signed [IN_W-1:0] value;
  logic signed [VAL_W-1:0] num;
  logic signed [VAL_W-1:0] den;
  logic signed [VAL_W-1:0] offset;
  logic done;
  logic div_zero;
  logic signed [PROD_W-1:0] result;
  modport ctrl(output start, value, num, den, offset, input done, div_zero, result);
  modport engine(input start, value, num, den, offset, output done, div_zero, result);
endinterface

// ===== spw_sync.sv
`timescale 1ns/10ps
module spw_sync #(
  parameter int W = 1
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

// ===== spw_scaler.sv
`timescale 1ns/10ps
module spw_scaler (
  input wire logic clock,
  input wire logic nrst,
  spw_scale_if.engine s
);
  import spw_pkg::*;
  logic busy;
  logic neg;
  logic [5:0] cnt;
  logic [PROD_W-1:0] quo;
  logic [VAL_W:0] rem;
  logic [VAL_W-1:0] dv;
  logic signed [PROD_W-1:0] offs;
  // ==========================================
  // Product and restoring division step
  wire signed [PROD_W-1:0] prod = PROD_W'(s.value) * spw_widen(s.num);
  wire [PROD_W-1:0] prod_mag = prod[PROD_W-1] ? PROD_W'(-prod) : prod;
  wire [VAL_W-1:0] den_mag = s.den[VAL_W-1] ? VAL_W'(-s.den) : s.den;
  wire [VAL_W:0] rem_sh = {rem[VAL_W-1:0], quo[PROD_W-1]};
  wire take = rem_sh >= {1'b0, dv};
  wire [PROD_W-1:0] quo_sh = {quo[PROD_W-2:0], take};
  wire signed [PROD_W-1:0] quo_sgn = neg ? PROD_W'(-quo_sh) : quo_sh;
  wire last = busy && (cnt == DIV_STEPS_M1);
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      busy <= 1'b0;
      neg <= 1'b0;
      cnt <= '0;
      quo <= '0;
      rem <= '0;
      dv <= '0;
      offs <= '0;
    end else if (s.start) begin
      busy <= (s.den != '0);
      neg <= prod[PROD_W-1] ^ s.den[VAL_W-1];
      cnt <= '0;
      quo <= prod_mag;
      rem <= '0;
      dv <= den_mag;
      offs <= spw_widen(s.offset);
    end else if (busy) begin
      busy <= !last;
      cnt <= cnt + 6'h01;
      quo <= quo_sh;
      rem <= take ? (rem_sh - {1'b0, dv}) : rem_sh;
    end
  end
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s.done <= 1'b0;
      s.div_zero <= 1'b0;
      s.result <= '0;
    end else begin
      s.done <= last || (s.start && s.den == '0);
      s.div_zero <= s.start && s.den == '0;
      if (last) begin
        s.result <= quo_sgn + offs;
      end
    end
  end
  a_scale_bounded: assert property (@(posedge clock) disable iff (!nrst)
    s.start |-> ##[1:50] s.done) else $error("scaler did not finish");
endmodule

// ===== spw_top.sv
`timescale 1ns/10ps
module spw_top (
  input wire logic clock,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [spw_pkg::AW-1:0] paddr,
  input wire logic [spw_pkg::VAL_W-1:0] pwdata,
  output logic [spw_pkg::VAL_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [spw_pkg::N_INST-1:0][spw_pkg::IN_W-1:0] scaler_input_value,
  input wire logic [spw_pkg::N_INST-1:0] write_trigger,
  input wire logic [spw_pkg::N_EXT-1:0] external_busy_input,
  input wire logic [spw_pkg::N_EXT-1:0] external_fail_input,
  input wire logic controller_inhibit,
  output logic [spw_pkg::N_INST-1:0] write_in_progress,
  output logic [spw_pkg::N_INST-1:0] write_failed,
  output logic irq,
  output logic store_req,
  output logic [spw_pkg::CODE_W-1:0] store_code,
  output logic [spw_pkg::SUB_W-1:0] store_subcode,
  input wire logic store_attr_valid,
  input wire logic store_code_exists,
  input wire logic store_sub_exists,
  input wire logic store_inhibit_only,
  input wire logic [spw_pkg::VAL_W-1:0] store_min,
  input wire logic [spw_pkg::VAL_W-1:0] store_max,
  output logic store_wr,
  output logic [spw_pkg::VAL_W-1:0] store_wr_data,
  input wire logic store_wr_ack
);
  import spw_pkg::*;
  spw_state_t state;
  spw_state_t next_state;
  logic [VAL_W-1:0] num_r [N_INST];
  logic [VAL_W-1:0] den_r [N_INST];
  logic [VAL_W-1:0] offs_r [N_INST];
  logic [CODE_W-1:0] code_r [N_INST];
  logic [SUB_W-1:0] sub_r [N_INST];
  logic [VAL_W-1:0] disp [N_INST];
  logic [N_INST-1:0] load_s;
  logic [N_INST-1:0] load_d;
  logic [N_INST-1:0] ch_busy;
  logic [N_INST-1:0] ch_fail;
  logic [N_EXT-1:0] ext_busy_s;
  logic [N_EXT-1:0] ext_fail_s;
  logic inhibit_s;
  logic [2:0] cur;
  logic [2:0] pick;
  logic any_wait;
  logic err_r;
  logic sc_start;
  logic signed [PROD_W-1:0] res_r;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_mask;
  logic [VAL_W-1:0] next_prdata;
  logic next_err;
  spw_scale_if sc();
  // ==========================================
  // Input synchronisers
  spw_sync #(.W(N_INST)) u_load_sync (.clock(clock), .nrst(nrst), .d(write_trigger), .q(load_s));
  spw_sync #(.W(2*N_EXT+1)) u_ext_sync (
    .clock(clock),
    .nrst(nrst),
    .d({controller_inhibit, external_fail_input, external_busy_input}),
    .q({inhibit_s, ext_fail_s, ext_busy_s})
  );
  spw_scaler u_scaler (.clock(clock), .nrst(nrst), .s(sc.engine));
  // ==========================================
  // APB decode
  function automatic logic [2:0] chan_of(input logic [AW-1:0] a);
    return a[AW-1:OFF_W];
  endfunction
  wire [2:0] a_inst = chan_of(paddr);
  wire [OFF_W-1:0] a_off = paddr[OFF_W-1:0];
  wire a_chan = a_inst < 3'(N_INST);
  wire a_glob = a_inst == GLOBAL_SLOT && (a_off == REG_IRQ_STAT || a_off == REG_IRQ_MASK);
  wire access = psel && penable && !pready;
  wire wr_en = psel && penable && pready && pwrite;
  wire finish = state == ST_DONE;
  wire [N_INST-1:0] load_edge = load_s & ~load_d;
  wire [N_INST-1:0] load_take = load_edge & ~ch_busy;
  wire [IRQ_W-1:0] irq_ev = finish ? (err_r ? IRQ_W'(1) << (4'(cur) + 4'(N_INST)) : IRQ_W'(1) << cur) : '0;
  wire [IRQ_W-1:0] irq_clr = (wr_en && a_inst == GLOBAL_SLOT && a_off == REG_IRQ_STAT) ? pwdata[IRQ_W-1:0] : '0;
  always_comb begin
    next_prdata = '0;
    if (a_chan) begin
      case (a_off)
        REG_NUM: next_prdata = num_r[a_inst];
        REG_DEN: next_prdata = den_r[a_inst];
        REG_OFFS: next_prdata = offs_r[a_inst];
        REG_CODE: next_prdata = VAL_W'(code_r[a_inst]);
        REG_SUB: next_prdata = VAL_W'(sub_r[a_inst]);
        REG_DISP: next_prdata = disp[a_inst];
        REG_INPUT: next_prdata = VAL_W'(signed'(scaler_input_value[a_inst]));
        REG_STAT: next_prdata = VAL_W'({write_failed[a_inst], write_in_progress[a_inst]});
        default: next_prdata = '0;
      endcase
    end else if (a_glob) begin
      next_prdata = (a_off == REG_IRQ_STAT) ? VAL_W'(irq_stat) : VAL_W'(irq_mask);
    end
  end
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= access;
      pslverr <= access && !a_chan && !a_glob;
      prdata <= (access && !pwrite) ? next_prdata : '0;
    end
  end
  // ==========================================
  // Channel configuration registers
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < N_INST; i++) begin
        num_r[i] <= NUM_RST;
        den_r[i] <= DEN_RST;
        offs_r[i] <= '0;
        code_r[i] <= '0;
        sub_r[i] <= '0;
      end
    end else if (wr_en && a_chan) begin
      case (a_off)
        REG_NUM: num_r[a_inst] <= pwdata;
        REG_DEN: den_r[a_inst] <= pwdata;
        REG_OFFS: offs_r[a_inst] <= pwdata;
        REG_CODE: code_r[a_inst] <= pwdata[CODE_W-1:0];
        REG_SUB: sub_r[a_inst] <= pwdata[SUB_W-1:0];
        default: ;
      endcase
    end
  end
  // ==========================================
  // Interrupts
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      irq_stat <= '0;
      irq_mask <= '0;
      irq <= 1'b0;
    end else begin
      irq_stat <= (irq_stat & ~irq_clr) | irq_ev;
      if (wr_en && a_inst == GLOBAL_SLOT && a_off == REG_IRQ_MASK) begin
        irq_mask <= pwdata[IRQ_W-1:0];
      end
      irq <= |(irq_stat & irq_mask);
    end
  end
  // ==========================================
  // Channel busy and fail
  always_comb begin
    pick = '0;
    any_wait = 1'b0;
    for (int i = N_INST - 1; i >= 0; i--) begin
      if (ch_busy[i]) begin
        pick = 3'(i);
        any_wait = 1'b1;
      end
    end
  end
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      load_d <= '0;
      ch_busy <= '0;
      ch_fail <= '0;
    end else begin
      load_d <= load_s;
      for (int i = 0; i < N_INST; i++) begin
        if (finish && cur == 3'(i)) begin
          ch_busy[i] <= 1'b0;
          ch_fail[i] <= err_r;
        end else if (load_take[i]) begin
          ch_busy[i] <= 1'b1;
          ch_fail[i] <= 1'b0;
        end
      end
    end
  end
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      write_in_progress <= '0;
      write_failed <= '0;
    end else begin
      write_in_progress <= ch_busy | ({ext_busy_s, EXT_FIRST'(0)});
      write_failed <= ch_fail | ({ext_fail_s, EXT_FIRST'(0)});
    end
  end
  // ==========================================
  // Write engine
  wire signed [PROD_W-1:0] lim_lo = spw_widen(store_min);
  wire signed [PROD_W-1:0] lim_hi = spw_widen(store_max);
  wire lim_bad = res_r < lim_lo || res_r > lim_hi;
  wire attr_bad = !store_code_exists || !store_sub_exists || lim_bad
    || (store_inhibit_only && !inhibit_s);
  assign sc.start = sc_start;
  assign sc.value = scaler_input_value[cur];
  assign sc.num = num_r[cur];
  assign sc.den = den_r[cur];
  assign sc.offset = offs_r[cur];
  always_comb begin
    next_state = state;
    next_err = err_r;
    case (state)
      ST_IDLE: begin
        next_err = 1'b0;
        if (any_wait) next_state = ST_SCALE;
      end
      ST_SCALE: if (sc.done) begin
        next_err = sc.div_zero;
        next_state = sc.div_zero ? ST_DONE : ST_LOOKUP;
      end
      ST_LOOKUP: if (store_attr_valid) begin
        next_err = attr_bad;
        next_state = attr_bad ? ST_DONE : ST_WRITE;
      end
      ST_WRITE: if (store_wr_ack) next_state = ST_DONE;
      ST_DONE: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state <= ST_IDLE;
      err_r <= 1'b0;
      cur <= '0;
      sc_start <= 1'b0;
      res_r <= '0;
    end else begin
      state <= next_state;
      err_r <= next_err;
      sc_start <= state == ST_IDLE && any_wait;
      if (state == ST_IDLE) cur <= pick;
      if (state == ST_SCALE && sc.done) res_r <= sc.result;
    end
  end
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < N_INST; i++) disp[i] <= '0;
    end else if (state == ST_SCALE && sc.done && !sc.div_zero) begin
      disp[cur] <= sc.result[VAL_W-1:0];
    end
  end
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      store_req <= 1'b0;
      store_wr <= 1'b0;
      store_code <= '0;
      store_subcode <= '0;
      store_wr_data <= '0;
    end else begin
      store_req <= next_state == ST_LOOKUP;
      store_wr <= next_state == ST_WRITE;
      store_code <= code_r[cur];
      store_subcode <= sub_r[cur];
      store_wr_data <= res_r[VAL_W-1:0];
    end
  end
  // ==========================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  a_trigger_sets_busy: assert property (load_take[0] |=> ##1 write_in_progress[0])
    else $error("trigger did not raise busy");
  a_busy_on_output: assert property (ch_busy[1] && !finish |=> write_in_progress[1])
    else $error("busy output low during write");
  a_fail_cleared: assert property (load_take[2] |=> !ch_fail[2] ##1 !write_failed[2])
    else $error("fail not cleared by trigger");
  a_missing_target: assert property (state == ST_LOOKUP && store_attr_valid && !store_code_exists
    |=> finish && err_r) else $error("missing target not failed");
  a_limit_fail: assert property (state == ST_LOOKUP && store_attr_valid && res_r > lim_hi
    |=> finish && err_r) else $error("limit breach not failed");
  a_inhibit_fail: assert property (state == ST_LOOKUP && store_attr_valid
    && store_inhibit_only && !inhibit_s |=> err_r && !store_wr) else $error("inhibit-only target written");
  a_ext_busy_seen: assert property (ext_busy_s[0] |=> write_in_progress[EXT_FIRST])
    else $error("external busy not shown");
  a_display_update: assert property (state == ST_SCALE && sc.done && !sc.div_zero
    |=> disp[cur] == $past(sc.result[VAL_W-1:0])) else $error("display not updated");
  a_drop_with_fail: assert property (finish && err_r |=> !ch_busy[$past(cur)] && ch_fail[$past(cur)])
    else $error("busy and fail not swapped together");
  a_ignore_busy: assert property (ch_busy[0] && load_edge[0] && !(finish && cur == 3'h0)
    |=> ch_busy[0] && $stable(ch_fail[0])) else $error("trigger not ignored while busy");
  a_config_apart: assert property (wr_en && a_inst == 3'h1 && a_off == REG_NUM |=> $stable(num_r[0]))
    else $error("channel settings not separate");
  c_write_ok: cover property (finish && !err_r);
  c_write_fail: cover property (finish && err_r);
  c_ext_fail: cover property (ext_fail_s[1] && write_failed[EXT_FIRST + 1]);
  c_two_waiting: cover property (ch_busy[0] && ch_busy[1]);
endmodule

// ===== spw_store_model.sv
`timescale 1ns/10ps
// ====================
// Parameter store: codes 1 and 2 exist, subcodes 0 to 3, code 2 is inhibit-only
module spw_store_model #(
  parameter logic signed [31:0] LIM = 32'sh000186A0
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [3:0] dly,
  input wire logic store_req,
  input wire logic [spw_pkg::CODE_W-1:0] store_code,
  input wire logic [spw_pkg::SUB_W-1:0] store_subcode,
  input wire logic store_wr,
  input wire logic [spw_pkg::VAL_W-1:0] store_wr_data,
  output logic store_attr_valid,
  output logic store_code_exists,
  output logic store_sub_exists,
  output logic store_inhibit_only,
  output logic [spw_pkg::VAL_W-1:0] store_min,
  output logic [spw_pkg::VAL_W-1:0] store_max,
  output logic store_wr_ack,
  output logic [spw_pkg::VAL_W-1:0] last_data,
  output logic [spw_pkg::CODE_W-1:0] last_code,
  output int wr_count
);
  import spw_pkg::*;
  logic [3:0] rcnt;
  logic [3:0] wcnt;
  // Attribute lines show their inverse outside the answer cycle
  assign store_code_exists = store_attr_valid ~^ (store_code == 16'h0001 || store_code == 16'h0002);
  assign store_sub_exists = store_attr_valid ~^ (store_subcode < 8'h04);
  assign store_inhibit_only = store_attr_valid ~^ (store_code == 16'h0002);
  assign store_min = store_attr_valid ? -LIM : LIM - 32'h1;
  assign store_max = store_attr_valid ? LIM : ~LIM;
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      {store_attr_valid, store_wr_ack, rcnt, wcnt, last_data, last_code} <= '0;
      wr_count <= 0;
    end else begin
      store_attr_valid <= 1'b0;
      store_wr_ack <= 1'b0;
      if (store_req && !store_attr_valid) begin
        rcnt <= (rcnt >= dly) ? 4'h0 : rcnt + 4'h1;
        store_attr_valid <= (rcnt >= dly);
      end
      if (store_wr && !store_wr_ack && wcnt >= dly) begin
        store_wr_ack <= 1'b1;
        wcnt <= 4'h0;
        last_data <= store_wr_data;
        last_code <= store_code;
        wr_count <= wr_count + 1;
      end else if (store_wr && !store_wr_ack) begin
        wcnt <= wcnt + 4'h1;
      end
    end
  end
endmodule

// ===== scaled_parameter_writer_tb_top.sv
`timescale 1ns/10ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin mismatches++; $display("[FAIL] %0t got %0h exp %0h", $time, (a), (b)); end end
module scaled_parameter_writer_tb_top;
  import spw_pkg::*;
  localparam logic signed [47:0] LIM = 48'sh0000000186A0;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, inh = 1'b0;
  logic [AW-1:0] paddr = '0;
  logic [VAL_W-1:0] pwdata = '0;
  logic [N_INST-1:0][IN_W-1:0] vin = '0;
  logic [N_INST-1:0] trig = '0, busy, fail;
  logic [N_EXT-1:0] ebusy = '0, efail = '0;
  logic [3:0] dly = 4'h0;
  logic pready, pslverr, irq, store_req, store_wr, store_attr_valid, store_code_exists;
  logic store_sub_exists, store_inhibit_only, store_wr_ack, e;
  logic [CODE_W-1:0] store_code, last_code;
  logic [SUB_W-1:0] store_subcode;
  logic [VAL_W-1:0] prdata, store_min, store_max, store_wr_data, last_data, q;
  int mismatches = 0, checked = 0, wr_count;
  always #20 clock = ~clock;
  spw_top i_dut (.clock(clock), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .scaler_input_value(vin), .write_trigger(trig), .external_busy_input(ebusy),
    .external_fail_input(efail), .controller_inhibit(inh), .write_in_progress(busy),
    .write_failed(fail), .irq(irq), .store_req(store_req), .store_code(store_code),
    .store_subcode(store_subcode), .store_attr_valid(store_attr_valid),
    .store_code_exists(store_code_exists), .store_sub_exists(store_sub_exists),
    .store_inhibit_only(store_inhibit_only), .store_min(store_min), .store_max(store_max),
    .store_wr(store_wr), .store_wr_data(store_wr_data), .store_wr_ack(store_wr_ack));
  spw_store_model i_store (.clock(clock), .nrst(nrst), .dly(dly), .store_req(store_req),
    .store_code(store_code), .store_subcode(store_subcode), .store_wr(store_wr),
    .store_wr_data(store_wr_data), .store_attr_valid(store_attr_valid),
    .store_code_exists(store_code_exists), .store_sub_exists(store_sub_exists),
    .store_inhibit_only(store_inhibit_only), .store_min(store_min), .store_max(store_max),
    .store_wr_ack(store_wr_ack), .last_data(last_data), .last_code(last_code), .wr_count(wr_count));
  // ====================
  // Tasks
  task automatic test_done;
    if (mismatches == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic tmo;
    mismatches++;
    test_done();
  endtask
  task automatic apb(input logic w, input int a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= 8'(a);
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) tmo();
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_busy(input int ch, input logic lvl);
    int n;
    n = 0;
    while (busy[ch] !== lvl && n < 400) begin
      @(posedge clock);
      n++;
    end
    if (busy[ch] !== lvl) tmo();
  endtask
  function automatic logic [32:0] expv(input logic signed [15:0] v, input logic signed [31:0] nu, de, of,
    input logic [31:0] cd, sb, input logic ih);
    logic signed [47:0] r;
    r = 48'sh0;
    if (de != 0) r = 48'(v) * 48'(nu) / 48'(de) + 48'(of);
    return {de == 0 || !(cd == 1 || cd == 2) || sb > 3 || (cd == 2 && !ih) || r > LIM || r < -LIM, r[31:0]};
  endfunction
  task automatic run(input int ch, input logic [15:0] v, input logic [31:0] nu, de, of, cd, sb);
    logic [32:0] x;
    int wc;
    apb(1, ch * 32 + REG_NUM, nu);
    apb(1, ch * 32 + REG_DEN, de);
    apb(1, ch * 32 + REG_OFFS, of);
    apb(1, ch * 32 + REG_CODE, cd);
    apb(1, ch * 32 + REG_SUB, sb);
    x = expv(v, nu, de, of, cd, sb, inh);
    wc = wr_count;
    vin[ch] <= v;
    @(posedge clock);
    trig[ch] <= 1'b1;
    @(posedge clock);
    wait_busy(ch, 1'b1);
    trig[ch] <= 1'b0;
    repeat (4) @(posedge clock);
    if (busy[ch] === 1'b1) trig[ch] <= 1'b1;
    wait_busy(ch, 1'b0);
    `CHK(fail[ch], x[32])
    `CHK(wr_count - wc, x[32] ? 0 : 1)
    if (!x[32]) begin
      `CHK(last_data, x[31:0])
      `CHK(last_code, cd[15:0])
      apb(0, ch * 32 + REG_DISP, 0);
      `CHK(q, x[31:0])
    end
    apb(0, ch * 32 + REG_INPUT, 0);
    `CHK(q, {{16{v[15]}}, v})
    apb(0, ch * 32 + REG_STAT, 0);
    `CHK(q, {30'h0, x[32], 1'b0})
    `CHK(busy[ch], 1'b0)
    trig[ch] <= 1'b0;
    repeat (3) @(posedge clock);
  endtask
  // ====================
  // Main sequence
  initial begin
    void'($urandom(32'h6B02268A));
    repeat (5) @(posedge clock);
    nrst <= 1'b1;
    apb(0, REG_NUM, 0);
    `CHK(q, NUM_RST)
    apb(0, REG_DEN, 0);
    `CHK(q, DEN_RST)
    apb(0, 8'hC8, 0);
    `CHK({e, q}, 33'h100000000)
    apb(1, 8'hC4, 32'h00000FFF);
    run(0, 16'hFFF9, 32'h3, 32'h2, 32'h5, 1, 0);
    repeat (2) @(posedge clock);
    `CHK(irq, 1'b1)
    apb(0, 8'hC0, 0);
    `CHK(q, 32'h00000001)
    apb(1, 8'hC0, 32'h00000001);
    repeat (2) @(posedge clock);
    `CHK(irq, 1'b0)
    apb(1, 8'hC4, 0);
    run(1, 16'h0010, 32'h1, 32'h1, 0, 3, 0);
    `CHK(irq, 1'b0)
    apb(0, 8'hC0, 0);
    `CHK(q, 32'h00000080)
    repeat (20) @(posedge clock);
    `CHK(fail[1], 1'b1)
    run(1, 16'h0010, 32'h2710, 32'h2710, 0, 1, 3);
    run(2, 16'h0005, 32'h1, 32'h1, 0, 1, 4);
    apb(0, 8'hC0, 0);
    `CHK(q[8], 1'b1)
    run(2, 16'h7FFF, 32'h100, 32'h1, 0, 1, 0);
    run(2, 16'h03E8, 32'h64, 32'h1, 0, 1, 0);
    run(2, 16'h03E8, 32'h64, 32'h1, 32'h1, 1, 0);
    run(2, 16'h0005, 32'h1, 32'h0, 0, 1, 0);
    run(2, 16'h0005, 32'h1, 32'h1, 0, 2, 0);
    inh <= 1'b1;
    repeat (4) @(posedge clock);
    run(2, 16'hFF00, 32'h7, 32'h3, 32'hFFFFFF00, 2, 1);
    trig[1:0] <= 2'b11;
    repeat (5) @(posedge clock);
    `CHK(busy[1:0], 2'b11)
    wait_busy(0, 1'b0);
    `CHK(busy[1], 1'b1)
    wait_busy(1, 1'b0);
    `CHK(last_data, 32'h00000010)
    `CHK(fail[1:0], 2'b00)
    trig[1:0] <= 2'b00;
    ebusy <= 3'b101;
    efail <= 3'b010;
    repeat (5) @(posedge clock);
    `CHK(busy, 6'b101000)
    `CHK(fail, 6'b010000)
    ebusy <= 3'b000;
    efail <= 3'b000;
    repeat (5) @(posedge clock);
    for (int i = 0; i < 24; i++) begin
      dly <= 4'($urandom_range(0, 3));
      inh <= 1'($urandom);
      repeat (4) @(posedge clock);
      run($urandom_range(0, 5), 16'($urandom), $urandom_range(1, 9000),
        ($urandom_range(0, 7) == 0) ? 0 : $urandom_range(1, 9000),
        $urandom_range(0, 800) - 400, $urandom_range(1, 3), $urandom_range(0, 4));
    end
    test_done();
  end
endmodule
